// [rtl/cct_pkg.sv]
package cct_pkg;

   // ******************************************************
   // Register addresses
   // ******************************************************
   localparam logic [15:0] ADDR_CLK_SEL   = 16'hFF40;
   localparam logic [15:0] ADDR_MODE      = 16'hFF48;
   localparam logic [15:0] ADDR_CC_FIRST  = 16'hFF4A;
   localparam logic [15:0] ADDR_CC_SECOND = 16'hFF4C;
   localparam logic [15:0] ADDR_COUNT     = 16'hFF4E;
   localparam logic [15:0] ADDR_CC_CTRL   = 16'hFF50;
   localparam logic [15:0] ADDR_OUT_CTRL  = 16'hFF51;
   localparam logic [15:0] ADDR_EDGE_CFG  = 16'hFF52;

   // ******************************************************
   // Reset values
   // ******************************************************
   localparam logic [7:0]  RST_CLK_SEL  = 8'h00;
   localparam logic [2:0]  RST_MODE     = 3'h0;
   localparam logic [7:0]  RST_CC_CTRL  = 8'h04;
   localparam logic [7:0]  RST_OUT_CTRL = 8'h00;
   localparam logic [7:0]  RST_EDGE_CFG = 8'h00;
   localparam logic [15:0] RST_COUNT    = 16'h0000;
   localparam logic [15:0] RST_CC       = 16'h0000;
   localparam logic [7:0]  RST_PRESC    = 8'h00;

   // ******************************************************
   // Field positions
   // ******************************************************
   localparam int MODE_OVF_BIT      = 0;
   localparam int MODE_FIELD_LSB    = 1;
   localparam int CC_FIRST_CAP_BIT  = 0;
   localparam int CC_FIRST_SRC_BIT  = 1;
   localparam int CC_SECOND_CAP_BIT = 2;
   localparam int CLK_OUT_EN_BIT    = 7;
   localparam int CNT_FIELD_LSB     = 4;
   localparam int OUT_EN_BIT        = 0;
   localparam int OUT_PWM_LVL_BIT   = 1;
   localparam int OUT_INV_EN_BIT    = 2;
   localparam int OUT_SET_BIT       = 3;
   localparam int OUT_CLR_BIT       = 4;
   localparam int OUT_ONESHOT_BIT   = 5;
   localparam int OUT_TRIG_BIT      = 6;
   localparam int EDGE_PRIMARY_LSB  = 2;
   localparam int EDGE_SECOND_LSB   = 4;
   // Command bits never stored, so they read back as zero
   localparam logic [7:0] OUT_STORE_MASK = 8'h27;

   // ******************************************************
   // Codes
   // ******************************************************
   localparam logic [2:0] CNT_SRC_EXT     = 3'h0;
   localparam logic [2:0] CNT_SRC_DOUBLE  = 3'h1;
   localparam logic [2:0] CNT_SRC_MAIN    = 3'h2;
   localparam logic [2:0] CNT_SRC_HALF    = 3'h3;
   localparam logic [2:0] CNT_SRC_QUARTER = 3'h4;
   localparam logic [2:0] CNT_SRC_WATCH   = 3'h7;
   localparam logic [3:0] CLKO_SUB        = 4'h0;
   localparam logic [3:0] CLKO_DIV_FIRST  = 4'h5;
   localparam logic [3:0] CLKO_DIV_LAST   = 4'hC;
   localparam logic [1:0] EDGE_FALL       = 2'h0;
   localparam logic [1:0] EDGE_RISE       = 2'h1;
   localparam logic [1:0] EDGE_BOTH       = 2'h3;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;

   typedef enum logic [2:0] {
      MODE_STOP       = 3'b000,
      MODE_PWM        = 3'b001,
      MODE_FREE       = 3'b010,
      MODE_FREE_EDGE  = 3'b011,
      MODE_EXTCLR     = 3'b100,
      MODE_EXTCLR_EDG = 3'b101,
      MODE_MCLR       = 3'b110,
      MODE_MCLR_EDGE  = 3'b111
   } cct_mode_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } cct_bus_req_t;

   typedef struct packed {
      logic meta;
      logic stable;
      logic prev;
   } cct_sync_t;

   typedef struct packed {
      logic [7:0]  clk_sel;
      cct_mode_t   mode;
      logic        ovf;
      logic [7:0]  cc_ctrl;
      logic [7:0]  out_ctrl;
      logic [7:0]  edge_cfg;
      logic [15:0] cc_first;
      logic [15:0] cc_second;
      logic [15:0] count;
      logic [7:0]  presc;
      logic        out_latch;
      logic        pin_out;
      logic        clk_out;
      logic        first_irq;
      logic        second_irq;
      logic        prim_irq;
      logic        sec_irq;
      logic [15:0] rdata;
   } cct_state_t;

endpackage

// [rtl/cct_pin_sync.sv]
`timescale 1ns/1ns
module cct_pin_sync (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   import cct_pkg::*;

   cct_sync_t st_reg;
   cct_sync_t st_next;

   // Only the second stage and its delayed copy feed the edge logic
   always_comb begin
      st_next        = st_reg;
      st_next.meta   = pin_in;
      st_next.stable = st_reg.meta;
      st_next.prev   = st_reg.stable;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.stable;
   assign rise  = st_reg.stable & ~st_reg.prev;
   assign fall  = ~st_reg.stable & st_reg.prev;

endmodule // cct_pin_sync

// [rtl/cct_timer16.sv]
`timescale 1ns/1ns
//Behaviour
//[R1] Bit 0 of capture/compare control picks capture or compare for first register
//[R2] First register in compare mode raises first match request on equal count
//[R3] First register captures count on reverse of valid primary edge or on valid secondary input edge
//[R4] Primary edge code maps input edge to opposite capture edge; code 11 no capture
//[R5] Both capture/compare registers are 16-bit words, written whole
//[R6] Bit 2 of capture/compare control picks capture or compare for second register
//[R7] Second register in compare mode raises second match request on equal count
//[R8] Second register captures count only on valid primary input edge
//[R9] Counter counts selected pulses, reads as a word, resets to zero
//[R10] Counter read goes through second register, overwriting its old value
//[R11] Three-bit count field picks external edge, prescaled main clock or watch tick
//[R12] Low four clock-select bits pick clock output source: subsystem or divided main
//[R13] Software programs clock output source first, then sets output enable bit
//[R14] Software stops the timer before changing the clock select register
//[R15] With external count source, software reads the counter register directly
//[R16] Mode 000 stops and holds counter at zero; any other code starts it
//[R17] Mode codes: PWM, free running, clear on edge, clear on first match
//[R18] Non-PWM output toggles on matches, odd codes also on valid edge
//[R19] Overflow flag sets on counter wrap, including clear at 0FFFFH match
//[R20] Software stops the timer before changing clear mode or output timing
//[R21] Software selects PWM mode before writing the first register
//[R22] Control resets to 04H; write only while stopped; no capture in match clear
//[R23] Output control holds latch set/reset, PWM level, invert, enable, one-shot
//[R24] Counter increments per qualified tick and wraps to zero
//[R25] Match-clear mode clears count on first match and keeps counting
//[R26] Latch set/reset and one-shot trigger bits read back as zero
module cct_timer16 (
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   input  wire cct_pkg::cct_bus_req_t cpu_req,
   output logic [15:0]                cpu_rdata,
   input  wire logic                  primary_capture_input,
   input  wire logic                  secondary_capture_input,
   input  wire logic                  watch_tick_output,
   input  wire logic                  subsystem_clock,
   output logic                       timer_output_pin,
   output logic                       programmable_clock_out,
   output logic                       first_match_irq,
   output logic                       second_match_irq,
   output logic                       primary_ext_irq,
   output logic                       secondary_ext_irq
);
   import cct_pkg::*;

   // ******************************************************
   // Pin synchronisers
   // ******************************************************
   logic prim_rise;
   logic prim_fall;
   logic sec_rise;
   logic sec_fall;
   logic sub_level;

   cct_pin_sync u_sync_prim (
      .mclk   (mclk),
      .resetn (resetn),
      .pin_in (primary_capture_input),
      .level  (),
      .rise   (prim_rise),
      .fall   (prim_fall)
   );

   cct_pin_sync u_sync_sec (
      .mclk   (mclk),
      .resetn (resetn),
      .pin_in (secondary_capture_input),
      .level  (),
      .rise   (sec_rise),
      .fall   (sec_fall)
   );

   // Subsystem clock is passed through as a synchronised level only
   cct_pin_sync u_sync_sub (
      .mclk   (mclk),
      .resetn (resetn),
      .pin_in (subsystem_clock),
      .level  (sub_level),
      .rise   (),
      .fall   ()
   );

   cct_state_t st_reg;
   cct_state_t st_next;

   // ******************************************************
   // Edge qualification
   // ******************************************************
   logic [1:0] prim_code;
   logic [1:0] sec_code;
   logic       prim_valid;
   logic       sec_valid;
   logic       prim_cap_edge;
   logic       first_trig;

   assign prim_code = st_reg.edge_cfg[EDGE_PRIMARY_LSB +: 2];
   assign sec_code  = st_reg.edge_cfg[EDGE_SECOND_LSB +: 2];
   assign prim_valid = (prim_code == EDGE_FALL && prim_fall) || (prim_code == EDGE_RISE && prim_rise) ||
                       (prim_code == EDGE_BOTH && (prim_rise || prim_fall));
   assign sec_valid  = (sec_code == EDGE_FALL && sec_fall) || (sec_code == EDGE_RISE && sec_rise) ||
                       (sec_code == EDGE_BOTH && (sec_rise || sec_fall));
   // First register captures on the edge opposite the valid one  [R4]
   assign prim_cap_edge = (prim_code == EDGE_FALL && prim_rise) || (prim_code == EDGE_RISE && prim_fall);
   assign first_trig = st_reg.cc_ctrl[CC_FIRST_SRC_BIT] ? prim_cap_edge : sec_valid; // [R3]

   // ******************************************************
   // Count tick and compare
   // ******************************************************
   logic [2:0] cnt_src;
   logic       tick;
   logic       run;
   logic       match_first;
   logic       match_second;
   logic       ext_clear;
   logic       match_clear;
   logic       ovf_set;
   logic       pwm_on;

   assign cnt_src = st_reg.clk_sel[CNT_FIELD_LSB +: 3];

   // The clock is taken as twice the main clock; slower rates come from the prescaler
   always_comb begin
      case (cnt_src)                                                          // [R11]
         CNT_SRC_EXT:     tick = prim_valid;
         CNT_SRC_DOUBLE:  tick = 1'b1;
         CNT_SRC_MAIN:    tick = st_reg.presc[0];
         CNT_SRC_HALF:    tick = &st_reg.presc[1:0];
         CNT_SRC_QUARTER: tick = &st_reg.presc[2:0];
         CNT_SRC_WATCH:   tick = watch_tick_output;
         default:         tick = 1'b0;
      endcase
   end

   assign run          = (st_reg.mode != MODE_STOP);                           // [R16]
   assign match_first  = run && tick && !st_reg.cc_ctrl[CC_FIRST_CAP_BIT] &&
                         (st_reg.count == st_reg.cc_first);                    // [R1] [R2]
   assign match_second = run && tick && !st_reg.cc_ctrl[CC_SECOND_CAP_BIT] &&
                         (st_reg.count == st_reg.cc_second);                   // [R6] [R7]
   assign ext_clear    = run && (st_reg.mode[2:1] == 2'b10) && prim_valid;     // [R17]
   assign match_clear  = (st_reg.mode[2:1] == 2'b11) && match_first;           // [R25]
   assign ovf_set      = run && tick && (st_reg.count == COUNT_MAX);           // [R19]
   assign pwm_on       = (st_reg.count[15:2] < st_reg.cc_first[15:2]);

   // ******************************************************
   // Next state
   // ******************************************************
   always_comb begin
      logic       toggle;
      logic [2:0] div_idx;
      logic [3:0] clko_sel;
      st_next  = st_reg;
      toggle   = 1'b0;
      clko_sel = st_reg.clk_sel[3:0];
      div_idx  = 3'(clko_sel - CLKO_DIV_FIRST);

      st_next.presc = st_reg.presc + 8'h01;

      if (!run) begin
         st_next.count = RST_COUNT;                                           // [R16]
      end else if (ext_clear || match_clear) begin
         st_next.count = RST_COUNT;                                           // [R17] [R25]
      end else if (tick) begin
         st_next.count = st_reg.count + 16'h0001;                             // [R9] [R24]
      end

      st_next.first_irq  = match_first;                                       // [R2] [R18]
      st_next.second_irq = match_second;                                      // [R7] [R18]
      st_next.prim_irq   = prim_valid;
      st_next.sec_irq    = sec_valid;
      st_next.rdata      = 16'h0000;

      // Register writes; hardware events below take priority
      if (cpu_req.wr) begin
         case (cpu_req.addr)
            ADDR_CLK_SEL:   st_next.clk_sel = cpu_req.wdata[7:0];           // [R12]
            ADDR_MODE: begin
               st_next.mode = cct_mode_t'(cpu_req.wdata[MODE_FIELD_LSB +: 3]);
               st_next.ovf  = cpu_req.wdata[MODE_OVF_BIT];
            end
            ADDR_CC_FIRST:  st_next.cc_first  = cpu_req.wdata;              // [R5]
            ADDR_CC_SECOND: st_next.cc_second = cpu_req.wdata;              // [R5]
            ADDR_CC_CTRL:   st_next.cc_ctrl   = cpu_req.wdata[7:0];
            ADDR_OUT_CTRL: begin
               st_next.out_ctrl = cpu_req.wdata[7:0] & OUT_STORE_MASK;       // [R26]
               if (cpu_req.wdata[OUT_SET_BIT]) begin
                  st_next.out_latch = 1'b1;                                  // [R23]
               end else if (cpu_req.wdata[OUT_CLR_BIT]) begin
                  st_next.out_latch = 1'b0;                                  // [R23]
               end else if (cpu_req.wdata[OUT_TRIG_BIT] && cpu_req.wdata[OUT_ONESHOT_BIT]) begin
                  st_next.out_latch = ~st_reg.out_latch;                     // [R23]
               end
            end
            ADDR_EDGE_CFG:  st_next.edge_cfg  = cpu_req.wdata[7:0];
            default: ;
         endcase
      end

      // Overflow set beats a software clear in the same cycle
      if (ovf_set) begin
         st_next.ovf = 1'b1;                                                  // [R19]
      end

      // Capture beats a bus write to the same register
      if (st_reg.cc_ctrl[CC_FIRST_CAP_BIT] && first_trig) begin
         st_next.cc_first = st_reg.count;                                     // [R3]
      end
      if (st_reg.cc_ctrl[CC_SECOND_CAP_BIT] && prim_valid) begin
         st_next.cc_second = st_reg.count;                                    // [R8]
      end

      if (cpu_req.rd) begin
         case (cpu_req.addr)
            ADDR_CLK_SEL:   st_next.rdata = {8'h00, st_reg.clk_sel};
            ADDR_MODE:      st_next.rdata = {12'h000, st_reg.mode, st_reg.ovf};
            ADDR_CC_FIRST:  st_next.rdata = st_reg.cc_first;
            ADDR_CC_SECOND: st_next.rdata = st_reg.cc_second;
            ADDR_COUNT: begin
               // Count is read through the second register, losing its old value
               st_next.cc_second = st_reg.count;                              // [R10]
               st_next.rdata     = st_reg.count;                              // [R10]
            end
            ADDR_CC_CTRL:   st_next.rdata = {8'h00, st_reg.cc_ctrl};
            ADDR_OUT_CTRL:  st_next.rdata = {8'h00, st_reg.out_ctrl};         // [R26]
            ADDR_EDGE_CFG:  st_next.rdata = {8'h00, st_reg.edge_cfg};
            default:        st_next.rdata = 16'h0000;
         endcase
      end

      // Output latch toggles on matches, and on edges in odd modes, only with inversion enabled, outside PWM and stop
      if (run && st_reg.mode != MODE_PWM && st_reg.out_ctrl[OUT_INV_EN_BIT]) begin
         toggle = match_first || match_second || (st_reg.mode[0] && prim_valid); // [R18]
      end
      if (toggle) begin
         st_next.out_latch = ~st_next.out_latch;                              // [R18]
      end

      if (!st_reg.out_ctrl[OUT_EN_BIT]) begin
         st_next.pin_out = 1'b0;                                              // [R23]
      end else if (st_reg.mode == MODE_PWM) begin
         st_next.pin_out = pwm_on ? st_reg.out_ctrl[OUT_PWM_LVL_BIT] : ~st_reg.out_ctrl[OUT_PWM_LVL_BIT];
      end else begin
         st_next.pin_out = st_next.out_latch;
      end

      // Main clock taken as presc[0]; each further bit halves it
      if (!st_reg.clk_sel[CLK_OUT_EN_BIT]) begin
         st_next.clk_out = 1'b0;
      end else if (clko_sel == CLKO_SUB) begin
         st_next.clk_out = sub_level;                                         // [R12]
      end else if (clko_sel >= CLKO_DIV_FIRST && clko_sel <= CLKO_DIV_LAST) begin
         st_next.clk_out = st_reg.presc[div_idx];                             // [R12]
      end else begin
         st_next.clk_out = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_reg           <= '0;
         st_reg.clk_sel   <= RST_CLK_SEL;
         st_reg.mode      <= MODE_STOP;
         st_reg.cc_ctrl   <= RST_CC_CTRL;                                     // [R22]
         st_reg.out_ctrl  <= RST_OUT_CTRL;
         st_reg.edge_cfg  <= RST_EDGE_CFG;
         st_reg.cc_first  <= RST_CC;
         st_reg.cc_second <= RST_CC;
         st_reg.count     <= RST_COUNT;                                       // [R9]
         st_reg.presc     <= RST_PRESC;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cpu_rdata              = st_reg.rdata;
   assign timer_output_pin       = st_reg.pin_out;
   assign programmable_clock_out = st_reg.clk_out;
   assign first_match_irq        = st_reg.first_irq;
   assign second_match_irq       = st_reg.second_irq;
   assign primary_ext_irq        = st_reg.prim_irq;
   assign secondary_ext_irq      = st_reg.sec_irq;

   // ******************************************************
   // Assertions
   // ******************************************************
   logic [15:0] count_q;
   assign count_q = st_reg.count;

   stop_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
      (st_reg.mode == MODE_STOP) |=> (count_q == 16'h0000))
      else $error("counter not held at zero while stopped");
   first_irq_a: assert property (@(posedge mclk) disable iff (!resetn) // [R2]
      match_first |=> first_match_irq ##1 !first_match_irq || match_first)
      else $error("first match request missing");
   second_irq_a: assert property (@(posedge mclk) disable iff (!resetn) // [R7]
      (run && tick && !st_reg.cc_ctrl[CC_SECOND_CAP_BIT] && count_q == st_reg.cc_second) |=> second_match_irq)
      else $error("second match request missing");
   ovf_set_a: assert property (@(posedge mclk) disable iff (!resetn) // [R19]
      (run && tick && count_q == 16'hFFFF) |=> (st_reg.ovf && count_q == 16'h0000))
      else $error("overflow not flagged on wrap");
   count_read_a: assert property (@(posedge mclk) disable iff (!resetn) // [R10]
      (cpu_req.rd && cpu_req.addr == ADDR_COUNT) |=> (cpu_rdata == $past(count_q) && st_reg.cc_second == $past(count_q)))
      else $error("counter read not routed through second register");
   match_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // [R25]
      match_clear |=> (count_q == 16'h0000) && first_match_irq)
      else $error("match clear did not restart counter");
   count_step_a: assert property (@(posedge mclk) disable iff (!resetn) // [R24]
      (run && tick && !ext_clear && !match_clear) |=> (count_q == 16'($past(count_q) + 16'h0001)))
      else $error("counter did not advance by one");
   cap_first_a: assert property (@(posedge mclk) disable iff (!resetn) // [R3]
      (st_reg.cc_ctrl[CC_FIRST_CAP_BIT] && first_trig) |=> (st_reg.cc_first == $past(count_q)))
      else $error("first register missed capture");
   cmd_zero_a: assert property (@(posedge mclk) disable iff (!resetn) // [R26]
      (cpu_req.rd && cpu_req.addr == ADDR_OUT_CTRL) |=> (cpu_rdata[OUT_SET_BIT] == 1'b0 &&
      cpu_rdata[OUT_CLR_BIT] == 1'b0 && cpu_rdata[OUT_TRIG_BIT] == 1'b0))
      else $error("command bits read back non-zero");

endmodule // cct_timer16

// [sim/cct_pin_model.sv]
`timescale 1ns/1ns
// ************************************************
// Far-side pins: capture inputs, watch tick, subsystem clock
// ************************************************
module cct_pin_model (
   input  wire logic mclk,
   output logic      primary_capture_input,
   output logic      secondary_capture_input,
   output logic      watch_tick_output,
   output logic      subsystem_clock
);
   logic [3:0] div_reg = 4'h0;

   initial begin
      primary_capture_input   = 1'b0;
      secondary_capture_input = 1'b0;
      watch_tick_output       = 1'b0;
      subsystem_clock         = 1'b0;
   end

   // Free-running slow sources so unselected paths still see activity
   always @(posedge mclk) begin
      div_reg <= div_reg + 4'h1;
      watch_tick_output <= (div_reg == 4'hF);
      if (div_reg[1:0] == 2'h3) begin
         subsystem_clock <= ~subsystem_clock;
      end
   end

   // Held several cycles so the synchroniser sees a clean level
   task pulse_primary(input int width);
      @(posedge mclk) primary_capture_input <= 1'b1;
      repeat (width) @(posedge mclk);
      primary_capture_input <= 1'b0;
   endtask

   task pulse_secondary(input int width);
      @(posedge mclk) secondary_capture_input <= 1'b1;
      repeat (width) @(posedge mclk);
      secondary_capture_input <= 1'b0;
   endtask
endmodule // cct_pin_model

// [sim/tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import cct_pkg::*;
   logic          mclk    = 1'b0;
   logic          resetn  = 1'b0;
   cct_bus_req_t  cpu_req = '0;
   logic [15:0]   cpu_rdata, rv, cap;
   logic          prim, sec, watch, subclk, tout, clko, irq1, irq2, pirq, sirq;
   int            num_errors = 0;
   int            check_count = 0;
   int            cycles = 0;
   int            n;
   logic          clk_seen;

   always #20 mclk = ~mclk;

   cct_pin_model u_pins (.mclk(mclk), .primary_capture_input(prim), .secondary_capture_input(sec),
      .watch_tick_output(watch), .subsystem_clock(subclk));
   cct_timer16 u_dut (.mclk(mclk), .resetn(resetn), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
      .primary_capture_input(prim), .secondary_capture_input(sec), .watch_tick_output(watch),
      .subsystem_clock(subclk), .timer_output_pin(tout), .programmable_clock_out(clko),
      .first_match_irq(irq1), .second_match_irq(irq2), .primary_ext_irq(pirq), .secondary_ext_irq(sirq));

   // ************************************************
   // Bus cycles
   // ************************************************
   task wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk) begin cpu_req.addr <= a; cpu_req.wdata <= d; cpu_req.wr <= 1'b1; end
      @(posedge mclk) cpu_req.wr <= 1'b0;
   endtask

   task rd_reg(input logic [15:0] a, output logic [15:0] d);
      @(posedge mclk) begin cpu_req.addr <= a; cpu_req.rd <= 1'b1; end
      @(posedge mclk) cpu_req.rd <= 1'b0;
      #1 d = cpu_rdata;
   endtask

   task results;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task test_reset;
      rd_reg(ADDR_CLK_SEL, rv);  `CHK(rv, 16'h0000)
      rd_reg(ADDR_MODE, rv);     `CHK(rv, 16'h0000)
      rd_reg(ADDR_CC_CTRL, rv);  `CHK(rv, 16'h0004)
      rd_reg(ADDR_OUT_CTRL, rv); `CHK(rv, 16'h0000)
      rd_reg(ADDR_COUNT, rv);    `CHK(rv, 16'h0000)
      rd_reg(16'hFF60, rv);      `CHK(rv, 16'h0000)
      $display("test_reset done");
   endtask

   task test_out_ctrl;
      wr_reg(ADDR_OUT_CTRL, 16'h007F);
      rd_reg(ADDR_OUT_CTRL, rv); `CHK(rv, 16'h0027)
      wr_reg(ADDR_OUT_CTRL, 16'h0011);
      @(posedge mclk) #1;        `CHK(tout, 1'b0)
      wr_reg(ADDR_OUT_CTRL, 16'h0009);
      @(posedge mclk) #1;        `CHK(tout, 1'b1)
      $display("test_out_ctrl done");
   endtask

   task test_interval;
      // Timer is stopped while every control register is changed
      wr_reg(ADDR_CLK_SEL, 16'h0010);
      wr_reg(ADDR_CC_CTRL, 16'h0000);
      wr_reg(ADDR_CC_FIRST, 16'h0002);
      wr_reg(ADDR_MODE, 16'h000C);
      n = 0;
      do begin @(posedge mclk) #1; n++; end while (irq1 !== 1'b1 && n < 50);
      `CHK(irq1, 1'b1)
      repeat (3) @(posedge mclk);
      #1;                        `CHK(irq1, 1'b1)
      wr_reg(ADDR_MODE, 16'h0000);
      rd_reg(ADDR_COUNT, rv);    `CHK(rv, 16'h0000)
      $display("test_interval done");
   endtask

   task test_capture;
      wr_reg(ADDR_CC_CTRL, 16'h0005);
      wr_reg(ADDR_EDGE_CFG, 16'h0014);
      wr_reg(ADDR_MODE, 16'h0004);
      repeat (10) @(posedge mclk);
      // Both pins rise together; the edges reach the capture registers three cycles later
      fork
         u_pins.pulse_primary(6);
         u_pins.pulse_secondary(6);
         begin
            n = 0;
            do begin @(posedge mclk) #1; n++; end while (pirq !== 1'b1 && n < 10);
            `CHK(pirq, 1'b1)
            `CHK(sirq, 1'b1)
         end
      join
      rd_reg(ADDR_CC_SECOND, cap); `CHK(cap, 16'h000D)
      rd_reg(ADDR_CC_FIRST, cap);  `CHK(cap, 16'h000D)
      rd_reg(ADDR_COUNT, rv);
      rd_reg(ADDR_COUNT, cap);   `CHK(cap, rv + 16'h0002)
      rd_reg(ADDR_CC_SECOND, rv); `CHK(rv, cap)
      wr_reg(ADDR_MODE, 16'h0000);
      $display("test_capture done");
   endtask

   task test_ext_count;
      wr_reg(ADDR_CLK_SEL, 16'h0000);
      wr_reg(ADDR_MODE, 16'h0004);
      repeat (3) u_pins.pulse_primary(4);
      rd_reg(ADDR_COUNT, rv);    `CHK(rv, 16'h0003)
      wr_reg(ADDR_MODE, 16'h0000);
      $display("test_ext_count done");
   endtask

   task test_output;
      wr_reg(ADDR_CC_CTRL, 16'h0000);
      wr_reg(ADDR_CLK_SEL, 16'h0010);
      wr_reg(ADDR_CC_FIRST, 16'h0003);
      wr_reg(ADDR_CC_SECOND, 16'h0001);
      wr_reg(ADDR_OUT_CTRL, 16'h0015);
      wr_reg(ADDR_MODE, 16'h000C);
      @(posedge mclk) #1;        `CHK(tout, 1'b0)
      `CHK(irq2, 1'b0)
      @(posedge mclk) #1;        `CHK(irq2, 1'b1)
      `CHK(tout, 1'b1)
      repeat (2) @(posedge mclk);
      #1;                        `CHK(irq1, 1'b1)
      `CHK(tout, 1'b0)
      // PWM: stop, pick the mode, then load the duty register
      wr_reg(ADDR_MODE, 16'h0000);
      wr_reg(ADDR_OUT_CTRL, 16'h0003);
      wr_reg(ADDR_MODE, 16'h0002);
      wr_reg(ADDR_CC_FIRST, 16'h0010);
      @(posedge mclk) #1;        `CHK(tout, 1'b1)
      repeat (20) @(posedge mclk);
      #1;                        `CHK(tout, 1'b0)
      wr_reg(ADDR_MODE, 16'h0000);
      $display("test_output done");
   endtask

   task test_clk_out;
      wr_reg(ADDR_CLK_SEL, 16'h0015);
      @(posedge mclk) #1;        `CHK(clko, 1'b0)
      wr_reg(ADDR_CLK_SEL, 16'h0095);
      @(posedge mclk) #1;
      clk_seen = clko;
      @(posedge mclk) #1;        `CHK(clko, ~clk_seen)
      $display("test_clk_out done");
   endtask

   task test_overflow;
      wr_reg(ADDR_CLK_SEL, 16'h0010);
      wr_reg(ADDR_CC_FIRST, 16'hFFFF);
      wr_reg(ADDR_MODE, 16'h000C);
      // The count has to walk the whole 16-bit range once
      repeat (65540) @(posedge mclk);
      rd_reg(ADDR_MODE, rv);     `CHK(rv, 16'h000D)
      wr_reg(ADDR_MODE, 16'h0000);
      rd_reg(ADDR_MODE, rv);     `CHK(rv, 16'h0000)
      $display("test_overflow done");
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 70000) begin
         num_errors++;
         $display("BAD t=%0t timeout", $time);
         results();
      end
   end

   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      test_reset();
      test_out_ctrl();
      test_interval();
      test_capture();
      test_ext_count();
      test_output();
      test_clk_out();
      test_overflow();
      results();
   end
endmodule // tb
